// file: hw/deflection_safety_and_blanking.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - Horizontal drive switches on before and off after the converter drive.
// - Alarm arms only when sense exceeds threshold with supply above enable level.
// - Drives switch off only after two horizontal lines of overvoltage.
// - Overvoltage shutdown sets the readable radiation alarm flag.
// - Shutdown stays latched until supply drop or alarm clear write.
// - Composite output gives four levels from lock and blanking states.
// - Blanking starts at first leading edge of vsync or discharge.
// - Blanking ends at trailing edge of the discharge pulse.
// - Blank hold select set (default) holds composite at blanking level.
// - Low supply, active protection or vertical drive off force blanking.
// - Soft start or stop runs at each converter drive switch, except the hard stop of the unlock cutoff.
// - Unlock cutoff stops converter at once and soft-starts on relock.
module deflection_safety_and_blanking
    import defl_safety_pkg::*;
#(
    parameter int STEP_CYCLES = SOFT_STEP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Analog monitor and timing inputs
    input wire defl_safety_pkg::monitor_s monitor,
    input wire defl_safety_pkg::vtiming_s vtiming,
    input wire logic hline,
    // Drive and status outputs
    output logic horizontal_drive_output,
    output logic converter_drive_output,
    output logic [1:0] lock_blank_composite_output,
    output logic irq
);
    import defl_safety_pkg::*;

    typedef enum {ST_OFF, ST_RAMP_UP, ST_ON, ST_RAMP_DOWN} soft_e;

    logic [7:0] control;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic radiation_alarm_flag;
    logic [1:0] line_count;
    logic [7:0] soft_level;
    logic [15:0] step_count;
    logic cut_active;
    logic vblank;
    logic vsync_q;
    logic vdis_q;
    logic locked_q;
    soft_e soft_state;

    wire logic wr_ctl = wr && (addr == ADDR_CONTROL);
    wire logic wr_irq = wr && (addr == ADDR_IRQ_STATUS);
    wire logic alarm_clear = wr_ctl && wdata[CTL_ALARM_CLEAR];
    wire logic armed = monitor.sense_over && monitor.supply_alarm_ok;
    wire logic alarm_fire = armed && (line_count == ALARM_DELAY_LINES - 2'h1) && hline;
    wire logic want_on = control[CTL_DRIVE_EN] && monitor.supply_ok && !radiation_alarm_flag
        && !(cut_active && monitor.locked);
    wire logic step_tick = (step_count == 16'(STEP_CYCLES - 1));
    wire logic vsync_rise = vtiming.vsync && !vsync_q;
    wire logic vdis_rise = vtiming.vdischarge && !vdis_q;
    wire logic vdis_fall = !vtiming.vdischarge && vdis_q;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    // Control register; clear bit self-resets
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            control <= CONTROL_RESET;
        end else if (wr_ctl) begin
            control <= {3'h0, 1'b0, wdata[3:0]};
        end
    end

    // Read mux, data one cycle after strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == ADDR_CONTROL) begin
                rdata <= control;
            end else if (addr == ADDR_STATUS) begin
                rdata <= {4'h0, vblank, monitor.locked, soft_state == ST_ON,
                    radiation_alarm_flag};
            end else if (addr == ADDR_IRQ_STATUS) begin
                rdata <= {5'h00, irq_status};
            end else if (addr == ADDR_IRQ_MASK) begin
                rdata <= {5'h00, irq_mask};
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_mask <= IRQ_RESET;
        end else if (wr && addr == ADDR_IRQ_MASK) begin
            irq_mask <= wdata[2:0];
        end
    end

    // Sticky events; set wins over write-one clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_status <= IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~(wr_irq ? wdata[2:0] : 3'h0))
                | {vblank == 1'b0 && (vsync_rise || vdis_rise),
                   locked_q && !monitor.locked, alarm_fire};
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // Overvoltage protection
    // ----------------------------------------------------------------
    // Line counter restarts whenever the condition drops
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            line_count <= 2'h0;
        end else if (!armed) begin
            line_count <= 2'h0;
        end else if (hline && line_count != ALARM_DELAY_LINES) begin
            line_count <= line_count + 2'h1;
        end
    end

    // Latched alarm; supply drop or clear bit resets it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            radiation_alarm_flag <= 1'b0;
        end else if (alarm_fire) begin
            radiation_alarm_flag <= 1'b1;
        end else if (!monitor.supply_ok || alarm_clear) begin
            radiation_alarm_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Soft start and stop sequencing
    // ----------------------------------------------------------------
    // Step timer for the ramp
    always_ff @(posedge ref_clk) begin
        if (!rst_b || step_tick) begin
            step_count <= 16'h0000;
        end else begin
            step_count <= step_count + 16'h0001;
        end
    end

    // Ramp state: rises when wanted, falls otherwise
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            soft_state <= ST_OFF;
            soft_level <= 8'h00;
        end else begin
            case (soft_state)
                ST_OFF: begin
                    if (want_on) begin
                        soft_state <= ST_RAMP_UP;
                    end
                end
                ST_RAMP_UP: begin
                    if (!want_on) begin
                        soft_state <= ST_RAMP_DOWN;
                    end else if (soft_level == SOFT_FULL) begin
                        soft_state <= ST_ON;
                    end else if (step_tick) begin
                        soft_level <= soft_level + 8'h01;
                    end
                end
                ST_ON: begin
                    if (!want_on) begin
                        soft_state <= ST_RAMP_DOWN;
                    end
                end
                default: begin
                    if (want_on) begin
                        soft_state <= ST_RAMP_UP;
                    end else if (soft_level == 8'h00) begin
                        soft_state <= ST_OFF;
                    end else if (step_tick) begin
                        soft_level <= soft_level - 8'h01;
                    end
                end
            endcase
        end
    end

    // Unlock cutoff: hard stop; on relock ramp dips below converter level, then soft restart
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cut_active <= 1'b0;
        end else if (control[CTL_UNLOCK_CUT] && !monitor.locked) begin
            cut_active <= 1'b1;
        end else if (soft_level < CDRIVE_ON_LEVEL) begin
            cut_active <= 1'b0;
        end
    end

    // Drive outputs from thresholds on the ramp
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            horizontal_drive_output <= 1'b0;
            converter_drive_output <= 1'b0;
        end else begin
            horizontal_drive_output <= soft_level >= HDRIVE_ON_LEVEL;
            converter_drive_output <= (soft_level >= CDRIVE_ON_LEVEL) && !cut_active
                && !(control[CTL_UNLOCK_CUT] && !monitor.locked);
        end
    end

    // ----------------------------------------------------------------
    // Vertical blanking and composite output
    // ----------------------------------------------------------------
    // Edge history
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            vsync_q <= 1'b0;
            vdis_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            vsync_q <= vtiming.vsync;
            vdis_q <= vtiming.vdischarge;
            locked_q <= monitor.locked;
        end
    end

    // Early blanking pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            vblank <= 1'b0;
        end else if (vdis_fall) begin
            vblank <= 1'b0;
        end else if (vsync_rise || vdis_rise) begin
            vblank <= 1'b1;
        end
    end

    // Four-level composite
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            lock_blank_composite_output <= LVL_UNLOCK_BLANK;
        end else if (vblank || control[CTL_BLANK_HOLD] || !monitor.supply_ok
                || radiation_alarm_flag || !control[CTL_VDRIVE_EN]) begin
            lock_blank_composite_output <= monitor.locked ? LVL_LOCK_BLANK
                : LVL_UNLOCK_BLANK;
        end else begin
            lock_blank_composite_output <= monitor.locked ? LVL_LOCK_ACTIVE
                : LVL_UNLOCK_ACTIVE;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_conv_needs_hdrive: assert property (
        converter_drive_output |-> horizontal_drive_output)
        else $error("converter drive on without horizontal drive");
    a_alarm_needs_arm: assert property (
        $rose(radiation_alarm_flag) |-> $past(armed))
        else $error("alarm set without armed condition");
    a_alarm_two_lines: assert property (
        $rose(radiation_alarm_flag) |-> $past(line_count) == 2'h1)
        else $error("alarm set before two lines");
    a_alarm_no_early: assert property (
        !armed |=> !$rose(radiation_alarm_flag))
        else $error("alarm set after condition dropped");
    a_alarm_latched: assert property (
        radiation_alarm_flag && monitor.supply_ok && !wr_ctl |=> radiation_alarm_flag)
        else $error("alarm released without cause");
    a_alarm_stops_drive: assert property (
        radiation_alarm_flag && soft_state == ST_OFF |=> !converter_drive_output)
        else $error("drive on during alarm");
    a_blank_start: assert property (
        (vsync_rise || vdis_rise) && !vdis_fall |=> vblank)
        else $error("blanking not started");
    a_blank_end: assert property (
        vdis_fall |=> !vblank)
        else $error("blanking not ended");
    a_forced_blank: assert property (
        !control[CTL_VDRIVE_EN] |=> !lock_blank_composite_output[0])
        else $error("composite not blanked");
    a_unlock_cut: assert property (
        control[CTL_UNLOCK_CUT] && !monitor.locked |=> !converter_drive_output)
        else $error("converter not cut on unlock");

    c_alarm_fire: cover property (alarm_fire);
    c_ramp_done: cover property (soft_state == ST_RAMP_UP ##1 soft_state == ST_ON);
    c_blank_pulse: cover property ($rose(vblank) ##[1:50] $fell(vblank));
    c_unlock_cut: cover property ($rose(cut_active));

endmodule : deflection_safety_and_blanking

// file: hw/defl_safety_pkg.sv
package defl_safety_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;

    // Control register bit positions
    localparam int CTL_DRIVE_EN = 0;
    localparam int CTL_BLANK_HOLD = 1;
    localparam int CTL_VDRIVE_EN = 2;
    localparam int CTL_UNLOCK_CUT = 3;
    localparam int CTL_ALARM_CLEAR = 4;

    // Control reset value: blank hold set, vertical drive on
    localparam logic [7:0] CONTROL_RESET = 8'h06;

    // Interrupt status bits
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_UNLOCK = 1;
    localparam int IRQ_VBLANK = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam logic [1:0] ALARM_DELAY_LINES = 2'h2;
    localparam int SOFT_STEP_CYCLES = 64;
    localparam logic [7:0] SOFT_FULL = 8'hff;
    localparam logic [7:0] HDRIVE_ON_LEVEL = 8'h20;
    localparam logic [7:0] CDRIVE_ON_LEVEL = 8'h80;

    // Composite output levels
    localparam logic [1:0] LVL_LOCK_ACTIVE = 2'h3;
    localparam logic [1:0] LVL_LOCK_BLANK = 2'h2;
    localparam logic [1:0] LVL_UNLOCK_ACTIVE = 2'h1;
    localparam logic [1:0] LVL_UNLOCK_BLANK = 2'h0;

    // Monitor inputs from analog comparators
    typedef struct packed {
        logic supply_ok;
        logic supply_alarm_ok;
        logic sense_over;
        logic locked;
    } monitor_s;

    // Vertical timing pulses
    typedef struct packed {
        logic vsync;
        logic vdischarge;
    } vtiming_s;

endpackage : defl_safety_pkg

// file: test/power_stage_model.sv
`timescale 1ns/10ps
// Power stage model: flags a converter stage driven without the horizontal stage
module power_stage_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Drives from the block
    input wire logic horizontal_drive_output,
    input wire logic converter_drive_output,
    // Sticky order fault
    output logic order_fault
);
    // Converter must only run under a running horizontal stage
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            order_fault <= 1'b0;
        end else if (converter_drive_output && !horizontal_drive_output) begin
            order_fault <= 1'b1;
        end
    end
endmodule : power_stage_model

// file: test/tb_deflection_safety_and_blanking.sv
`timescale 1ns/10ps
module tb_deflection_safety_and_blanking;
    import defl_safety_pkg::*;
    typedef struct packed {
        logic [7:0] ctl;
        logic locked;
        logic vdis;
        logic [1:0] lvl;
    } row_s;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    monitor_s mon = 4'h9;
    vtiming_s vt = 2'h0;
    logic hline = 1'b0;
    logic hdrv;
    logic cdrv;
    logic [1:0] comp;
    logic irq;
    logic order_fault;
    int mismatches = 0;
    int tests_run = 0;
    // Composite cases: control, lock, discharge, level
    row_s rows [7] = '{'{8'h04, 1'b1, 1'b0, LVL_LOCK_ACTIVE}, '{8'h04, 1'b1, 1'b1, LVL_LOCK_BLANK},
        '{8'h04, 1'b0, 1'b0, LVL_UNLOCK_ACTIVE}, '{8'h04, 1'b0, 1'b1, LVL_UNLOCK_BLANK},
        '{8'h06, 1'b1, 1'b0, LVL_LOCK_BLANK}, '{8'h06, 1'b0, 1'b0, LVL_UNLOCK_BLANK},
        '{8'h00, 1'b1, 1'b0, LVL_LOCK_BLANK}};

    // Clock
    always #10 ref_clk = ~ref_clk;

    deflection_safety_and_blanking #(.STEP_CYCLES(1)) i_deflection_safety_and_blanking (
        .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .monitor(mon), .vtiming(vt), .hline(hline),
        .horizontal_drive_output(hdrv), .converter_drive_output(cdrv),
        .lock_blank_composite_output(comp), .irq(irq));

    power_stage_model i_power_stage_model (.ref_clk(ref_clk), .rst_b(rst_b),
        .horizontal_drive_output(hdrv), .converter_drive_output(cdrv),
        .order_fault(order_fault));

    // ----------------------------------------------------------------
    // Bench tasks
    // ----------------------------------------------------------------
    task automatic close_out;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_out

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk_out(rdata & m, exp);
    endtask : rd_reg

    task automatic wait_drv(input logic [1:0] exp);
        int n;
        n = 0;
        #1;
        while ({hdrv, cdrv} !== exp && n < 1000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk_out({6'h00, hdrv, cdrv}, {6'h00, exp});
        chk_out({7'h00, order_fault}, 8'h00);
        if (n >= 1000) begin
            close_out();
        end
    endtask : wait_drv

    task automatic lines(input int k);
        repeat (k) begin
            @(posedge ref_clk);
            hline <= 1'b1;
            @(posedge ref_clk);
            hline <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask : lines

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        chk_out({3'h0, hdrv, cdrv, comp, irq}, 8'h00);
        rd_reg(ADDR_CONTROL, 8'hff, CONTROL_RESET);
        rd_reg(4'hf, 8'hff, 8'h00);
        // Table of composite cases
        foreach (rows[i]) begin
            wr_reg(ADDR_CONTROL, rows[i].ctl);
            mon.locked <= rows[i].locked;
            vt.vdischarge <= rows[i].vdis;
            repeat (3) @(posedge ref_clk);
            #1;
            chk_out({6'h00, comp}, {6'h00, rows[i].lvl});
        end
        // Phase-in order
        mon <= 4'h9;
        wr_reg(ADDR_CONTROL, 8'h05);
        wait_drv(2'h2);
        wait_drv(2'h3);
        // Sense high with supply below alarm level
        mon.sense_over <= 1'b1;
        lines(3);
        rd_reg(ADDR_STATUS, 8'h01, 8'h00);
        // Spike shorter than two lines
        mon.supply_alarm_ok <= 1'b1;
        lines(1);
        mon.sense_over <= 1'b0;
        lines(2);
        rd_reg(ADDR_STATUS, 8'h01, 8'h00);
        chk_out({6'h00, hdrv, cdrv}, 8'h03);
        // Real overvoltage
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        mon.sense_over <= 1'b1;
        lines(1);
        rd_reg(ADDR_STATUS, 8'h01, 8'h00);
        lines(1);
        rd_reg(ADDR_STATUS, 8'h01, 8'h01);
        chk_out({7'h00, irq}, 8'h01);
        wait_drv(2'h2);
        wait_drv(2'h0);
        mon.sense_over <= 1'b0;
        lines(2);
        rd_reg(ADDR_STATUS, 8'h01, 8'h01);
        chk_out({6'h00, comp}, {6'h00, LVL_LOCK_BLANK});
        wr_reg(ADDR_CONTROL, 8'h15);
        rd_reg(ADDR_STATUS, 8'h01, 8'h00);
        wait_drv(2'h3);
        wr_reg(ADDR_IRQ_STATUS, 8'h01);
        #1;
        chk_out({7'h00, irq}, 8'h00);
        // Masked alarm, then cleared by supply drop
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        mon.sense_over <= 1'b1;
        lines(2);
        rd_reg(ADDR_STATUS, 8'h01, 8'h01);
        chk_out({7'h00, irq}, 8'h00);
        mon <= 4'h1;
        lines(1);
        rd_reg(ADDR_STATUS, 8'h01, 8'h00);
        chk_out({6'h00, comp}, {6'h00, LVL_LOCK_BLANK});
        mon <= 4'hd;
        wait_drv(2'h3);
        // Blanking from vsync to end of discharge
        vt.vsync <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk_out({6'h00, comp}, {6'h00, LVL_LOCK_BLANK});
        rd_reg(ADDR_STATUS, 8'h08, 8'h08);
        vt <= 2'h1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk_out({6'h00, comp}, {6'h00, LVL_LOCK_BLANK});
        vt <= 2'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk_out({6'h00, comp}, {6'h00, LVL_LOCK_ACTIVE});
        // Unlock cutoff and restart on relock
        wr_reg(ADDR_CONTROL, 8'h0d);
        mon.locked <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_out({6'h00, hdrv, cdrv}, 8'h02);
        mon.locked <= 1'b1;
        wait_drv(2'h3);
        close_out();
    end
endmodule : tb_deflection_safety_and_blanking
